/* File: hw/shift_digit_alu.sv */
// Purpose: Combinational shift and digit-rotate datapath with flag update.
// Assumes: Operand and accumulator are stable while the result is used.
// Notes: Undocumented flag bits 5 and 3 are returned as zero by all four operations.
`timescale 1ns/1ps
module shift_digit_alu import shift_digit_pkg::*; (
	input wire alu_op_t op,
	input wire logic [7:0] operand,
	input wire logic [7:0] acc,
	input wire logic [7:0] flagsIn,
	output logic [7:0] result,
	output logic [7:0] accOut,
	output logic [7:0] flagsOut
);

	// ----------------------------------------------------------------
	// Flag builder shared by all four operations
	// ----------------------------------------------------------------
	function automatic logic [7:0] flagsFor(input logic [7:0] v, input logic carry);
		logic [7:0] f;
		f = 8'h00;
		f[FLAG_S] = v[7];
		f[FLAG_Z] = (v == 8'h00);
		f[FLAG_PV] = ~^v;
		f[FLAG_C] = carry;
		return f;
	endfunction : flagsFor

	// ----------------------------------------------------------------
	// Operation select
	// ----------------------------------------------------------------
	// Half-carry and subtract stay zero because flagsFor never sets them
	always_comb begin
		result = operand;
		accOut = acc;
		flagsOut = flagsIn;
		unique case (op)
			ALU_ARITH_SHIFT_RIGHT: begin
				result = {operand[7], operand[7:1]}; // RQ1 RQ2
				flagsOut = flagsFor({operand[7], operand[7:1]}, operand[0]); // RQ4
			end
			ALU_LOGIC_SHIFT_RIGHT: begin
				result = {1'b0, operand[7:1]}; // RQ3
				flagsOut = flagsFor({1'b0, operand[7:1]}, operand[0]); // RQ5
			end
			ALU_DIGIT_ROTATE_LEFT: begin
				result = {operand[3:0], acc[3:0]}; // RQ10
				accOut = {acc[7:4], operand[7:4]}; // RQ12
				flagsOut = flagsFor({acc[7:4], operand[7:4]}, flagsIn[FLAG_C]); // RQ13
			end
			ALU_DIGIT_ROTATE_RIGHT: begin
				result = {acc[3:0], operand[7:4]}; // RQ11
				accOut = {acc[7:4], operand[3:0]}; // RQ12
				flagsOut = flagsFor({acc[7:4], operand[3:0]}, flagsIn[FLAG_C]); // RQ13
			end
			default: begin
				result = operand;
			end
		endcase
	end

endmodule : shift_digit_alu

/* File: hw/shift_digit_pkg.sv */
// Purpose: Shared constants and types for the shift and digit-rotate slice.
// Assumes: One T-state per enabled clock; byte-wide memory behind a simple handshake.
// Notes: Register offsets are byte addresses on a 32-bit APB slave.
//
// Functional notes
// RQ1: Arithmetic right shift moves bits toward bit 0; old bit 0 goes to carry.
// RQ2: Arithmetic right shift keeps result bit 7 equal to operand bit 7.
// RQ3: Logical right shift moves bits toward bit 0, carry gets bit 0, bit 7 cleared.
// RQ4: Arithmetic shift flags: sign bit 7, zero, even parity, clear half-carry and subtract.
// RQ5: Logical shift flags: sign clear, zero, even parity, half/subtract clear, carry old bit 0.
// RQ6: Prefix CB then 2E/3E shift memory at pointer pair; 00111rrr shifts a register.
// RQ7: Indexed forms are DD or FD, then CB, displacement, then the same operation byte.
// RQ8: Register field: 000 B, 001 C, 010 D, 011 E, 100 H, 101 L, 111 accumulator.
// RQ9: Shift timing: register 2/8, pointer 4/15, indexed 6/23 machine cycles/states.
// RQ10: ED 6F: new memory = {mem low, acc low}; new acc low = mem high.
// RQ11: ED 67: new memory = {acc low, mem high}; new acc low = mem low.
// RQ12: Digit rotates never change the accumulator's upper four bits.
// RQ13: Digit rotate flags from new accumulator; half/subtract cleared; carry kept.
// RQ14: Digit rotates take 5 machine cycles and 18 states, split 4,4,3,4,3.
// RQ15: Digit rotates address memory with the 16-bit pointer pair.
// RQ16: Memory operands: add signed displacement, read, compute, write back same address.
package shift_digit_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_INSTR = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_ACCF = 8'h0c;
	localparam logic [7:0] ADDR_BCDE = 8'h10;
	localparam logic [7:0] ADDR_PTR = 8'h14;
	localparam logic [7:0] ADDR_INDEX = 8'h18;
	localparam logic [7:0] ADDR_TIMING = 8'h1c;

	localparam int CTRL_START = 0;
	localparam int CTRL_CLEAR = 1;
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_ILLEGAL = 2;

	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [31:0] RST_INSTR = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Flag positions
	// ----------------------------------------------------------------
	localparam int FLAG_S = 7;
	localparam int FLAG_Z = 6;
	localparam int FLAG_H = 4;
	localparam int FLAG_PV = 2;
	localparam int FLAG_N = 1;
	localparam int FLAG_C = 0;

	// ----------------------------------------------------------------
	// Opcode encodings
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_PREFIX_SHIFT = 8'hcb;
	localparam logic [7:0] OP_PREFIX_FIRST = 8'hdd;
	localparam logic [7:0] OP_PREFIX_SECOND = 8'hfd;
	localparam logic [7:0] OP_PREFIX_EXT = 8'hed;
	localparam logic [7:0] OP_DIGIT_LEFT = 8'h6f;
	localparam logic [7:0] OP_DIGIT_RIGHT = 8'h67;
	localparam logic [4:0] SEL_ARITH = 5'h05;
	localparam logic [4:0] SEL_LOGIC = 5'h07;
	localparam logic [2:0] REG_B = 3'h0;
	localparam logic [2:0] REG_C = 3'h1;
	localparam logic [2:0] REG_D = 3'h2;
	localparam logic [2:0] REG_E = 3'h3;
	localparam logic [2:0] REG_H = 3'h4;
	localparam logic [2:0] REG_L = 3'h5;
	localparam logic [2:0] REG_MEM = 3'h6;
	localparam logic [2:0] REG_A = 3'h7;

	typedef enum logic [2:0] {
		ALU_NONE = 3'h0,
		ALU_ARITH_SHIFT_RIGHT = 3'h1,
		ALU_LOGIC_SHIFT_RIGHT = 3'h2,
		ALU_DIGIT_ROTATE_LEFT = 3'h3,
		ALU_DIGIT_ROTATE_RIGHT = 3'h4
	} alu_op_t;

	typedef enum logic [1:0] {
		MODE_REG = 2'h0,
		MODE_PTR = 2'h1,
		MODE_IDX = 2'h2,
		MODE_DIGIT = 2'h3
	} mode_t;

	// ----------------------------------------------------------------
	// Timing: states, machine cycles, memory read and write states
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [4:0] total;
		logic [2:0] mCycles;
		logic [4:0] rdAt;
		logic [4:0] wrAt;
	} timing_t;

	localparam timing_t TIME_REG = '{total: 5'd8, mCycles: 3'd2, rdAt: 5'd0, wrAt: 5'd0};
	localparam timing_t TIME_PTR = '{total: 5'd15, mCycles: 3'd4, rdAt: 5'd8, wrAt: 5'd12};
	localparam timing_t TIME_IDX = '{total: 5'd23, mCycles: 3'd6, rdAt: 5'd16, wrAt: 5'd20};
	localparam timing_t TIME_DIGIT = '{total: 5'd18, mCycles: 3'd5, rdAt: 5'd8, wrAt: 5'd15};

endpackage : shift_digit_pkg

/* File: hw/shift_digit_rotate_unit.sv */
// Purpose: Decode and sequence the shift and digit-rotate group over APB.
// Assumes: Memory port is same-clock logic; memReady may stretch any access.
// Notes: One T-state per enabled clock; waits on memReady stretch the count.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
module shift_digit_rotate_unit import shift_digit_pkg::*; (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [15:0] memAddr,
	output logic memRead,
	output logic memWrite,
	output logic [7:0] memWdata,
	input wire logic [7:0] memRdata,
	input wire logic memReady
);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01
	} state_t;

	// Architectural state visible to software
	logic [7:0] acc, flags, regB, regC, regD, regE, regH, regL;
	logic [15:0] idxFirst, idxSecond;
	logic [31:0] instr;
	logic done, illegal;
	logic [4:0] lastStates;
	logic [2:0] lastCycles;

	// Sequencer state
	state_t state;
	logic [4:0] tCount;
	alu_op_t opHold;
	mode_t modeHold;
	logic [2:0] regHold;
	timing_t timeHold;
	logic [7:0] resultHold, accHold, flagsHold;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] regRead(input logic [2:0] sel, input logic [7:0] b,
			input logic [7:0] c, input logic [7:0] d, input logic [7:0] e,
			input logic [7:0] h, input logic [7:0] l, input logic [7:0] a);
		logic [7:0] v;
		v = a;
		unique case (sel)
			REG_B: v = b;
			REG_C: v = c;
			REG_D: v = d;
			REG_E: v = e;
			REG_H: v = h;
			REG_L: v = l;
			default: v = a;
		endcase
		return v;
	endfunction : regRead

	function automatic alu_op_t shiftOp(input logic [4:0] sel);
		if (sel == SEL_ARITH)
			return ALU_ARITH_SHIFT_RIGHT;
		if (sel == SEL_LOGIC)
			return ALU_LOGIC_SHIFT_RIGHT;
		return ALU_NONE;
	endfunction : shiftOp

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic apbWrite, apbSetup, mapped, busy;
	assign busy = (state != ST_IDLE);
	assign apbWrite = ce && psel && penable && pwrite;
	assign apbSetup = ce && psel && !penable;
	assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_INSTR) || (paddr == ADDR_STATUS) ||
		(paddr == ADDR_ACCF) || (paddr == ADDR_BCDE) || (paddr == ADDR_PTR) ||
		(paddr == ADDR_INDEX) || (paddr == ADDR_TIMING);
	// No wait states; a frozen block holds the master off
	assign pready = ce;
	assign pslverr = psel && penable && !mapped;

	// ----------------------------------------------------------------
	// Instruction decode from the staged instruction word
	// ----------------------------------------------------------------
	logic [7:0] byte0, byte1, byte2, byte3;
	alu_op_t dOp;
	mode_t dMode;
	logic [2:0] dReg;
	logic [15:0] dAddr;
	timing_t dTime;
	assign byte0 = instr[7:0];
	assign byte1 = instr[15:8];
	assign byte2 = instr[23:16];
	assign byte3 = instr[31:24];

	// Anything outside this slice decodes to ALU_NONE and is flagged illegal
	always_comb begin
		dOp = ALU_NONE;
		dMode = MODE_REG;
		dReg = byte1[2:0];
		dAddr = {regH, regL};
		dTime = TIME_REG;
		if (byte0 == OP_PREFIX_SHIFT) begin
			dOp = shiftOp(byte1[7:3]); // RQ6
			if (byte1[2:0] == REG_MEM) begin
				dMode = MODE_PTR; // RQ6
				dTime = TIME_PTR; // RQ9
			end
		end else if ((byte0 == OP_PREFIX_FIRST || byte0 == OP_PREFIX_SECOND) &&
				byte1 == OP_PREFIX_SHIFT && byte3[2:0] == REG_MEM) begin
			dOp = shiftOp(byte3[7:3]); // RQ7
			dMode = MODE_IDX;
			dTime = TIME_IDX; // RQ9
			dReg = REG_MEM;
			// Signed displacement added to the selected index register
			dAddr = ((byte0 == OP_PREFIX_FIRST) ? idxFirst : idxSecond) +
				{{8{byte2[7]}}, byte2}; // RQ7 RQ16
		end else if (byte0 == OP_PREFIX_EXT) begin
			dMode = MODE_DIGIT;
			dTime = TIME_DIGIT; // RQ14
			dReg = REG_MEM;
			if (byte1 == OP_DIGIT_LEFT)
				dOp = ALU_DIGIT_ROTATE_LEFT; // RQ10
			else if (byte1 == OP_DIGIT_RIGHT)
				dOp = ALU_DIGIT_ROTATE_RIGHT; // RQ11
		end
	end

	// ----------------------------------------------------------------
	// Datapath
	// ----------------------------------------------------------------
	logic [7:0] aluOperand, aluResult, aluAcc, aluFlags;
	// Register form reads the file; memory forms feed the read data straight in
	assign aluOperand = (modeHold == MODE_REG) ?
		regRead(regHold, regB, regC, regD, regE, regH, regL, acc) : memRdata; // RQ8

	shift_digit_alu alu (
		.op(opHold),
		.operand(aluOperand),
		.acc(acc),
		.flagsIn(flags),
		.result(aluResult),
		.accOut(aluAcc),
		.flagsOut(aluFlags)
	);

	// ----------------------------------------------------------------
	// Sequencer: T-state counter with memory stalls
	// ----------------------------------------------------------------
	logic memUse, advance, lastState, startReq, readTaken;
	assign memUse = (modeHold != MODE_REG);
	assign memRead = (state == ST_RUN) && memUse && (tCount == timeHold.rdAt); // RQ16
	assign memWrite = (state == ST_RUN) && memUse && (tCount == timeHold.wrAt); // RQ16
	assign advance = !(memRead || memWrite) || memReady;
	assign lastState = (state == ST_RUN) && advance && (tCount == timeHold.total - 5'd1); // RQ9
	assign startReq = apbWrite && (paddr == ADDR_CTRL) && pwdata[CTRL_START] && !busy;
	assign readTaken = ce && memRead && memReady;

	// State and counter
	always_ff @(posedge clk) begin
		if (srst) begin
			state <= ST_IDLE;
			tCount <= 5'd0;
		end else if (ce) begin
			unique case (state)
				ST_IDLE: begin
					tCount <= 5'd0;
					if (startReq && dOp != ALU_NONE)
						state <= ST_RUN;
				end
				ST_RUN: begin
					if (lastState)
						state <= ST_IDLE;
					else if (advance)
						tCount <= tCount + 5'd1; // RQ9 RQ14
				end
			endcase
		end
	end

	// Decoded instruction held for the whole execution
	always_ff @(posedge clk) begin
		if (srst) begin
			opHold <= ALU_NONE;
			modeHold <= MODE_REG;
			regHold <= REG_A;
			timeHold <= TIME_REG;
			memAddr <= RST_WORD;
		end else if (ce && state == ST_IDLE && startReq) begin
			opHold <= dOp;
			modeHold <= dMode;
			regHold <= dReg;
			timeHold <= dTime;
			memAddr <= dAddr; // RQ15 RQ16
		end
	end

	// Result captured at the read so the write-back data comes from flops
	always_ff @(posedge clk) begin
		if (srst) begin
			resultHold <= RST_BYTE;
			accHold <= RST_BYTE;
			flagsHold <= RST_BYTE;
		end else if (readTaken) begin
			resultHold <= aluResult; // RQ16
			accHold <= aluAcc;
			flagsHold <= aluFlags;
		end
	end
	assign memWdata = resultHold; // RQ16

	// ----------------------------------------------------------------
	// Register file: software writes while idle, commit at the last state
	// ----------------------------------------------------------------
	// Writes during execution are dropped so operands cannot change mid-flight
	always_ff @(posedge clk) begin
		if (srst) begin
			acc <= RST_BYTE;
			flags <= RST_BYTE;
			regB <= RST_BYTE;
			regC <= RST_BYTE;
			regD <= RST_BYTE;
			regE <= RST_BYTE;
			regH <= RST_BYTE;
			regL <= RST_BYTE;
			idxFirst <= RST_WORD;
			idxSecond <= RST_WORD;
			instr <= RST_INSTR;
		end else if (ce) begin
			if (lastState) begin
				if (modeHold == MODE_REG) begin
					flags <= aluFlags; // RQ4 RQ5
					unique case (regHold)
						REG_B: regB <= aluResult;
						REG_C: regC <= aluResult;
						REG_D: regD <= aluResult;
						REG_E: regE <= aluResult;
						REG_H: regH <= aluResult;
						REG_L: regL <= aluResult;
						default: acc <= aluResult; // RQ8
					endcase
				end else begin
					flags <= flagsHold; // RQ4 RQ5 RQ13
					if (modeHold == MODE_DIGIT)
						acc <= accHold; // RQ12
				end
			end else if (apbWrite && !busy) begin
				unique case (paddr)
					ADDR_INSTR: instr <= pwdata;
					ADDR_ACCF: begin
						acc <= pwdata[7:0];
						flags <= pwdata[15:8];
					end
					ADDR_BCDE: begin
						regB <= pwdata[31:24];
						regC <= pwdata[23:16];
						regD <= pwdata[15:8];
						regE <= pwdata[7:0];
					end
					ADDR_PTR: begin
						regH <= pwdata[15:8];
						regL <= pwdata[7:0];
					end
					ADDR_INDEX: begin
						idxFirst <= pwdata[15:0];
						idxSecond <= pwdata[31:16];
					end
					default: instr <= instr;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Status: sticky done and illegal; setting beats a same-cycle clear
	// ----------------------------------------------------------------
	logic clearReq;
	assign clearReq = apbWrite && (paddr == ADDR_CTRL) && pwdata[CTRL_CLEAR];
	always_ff @(posedge clk) begin
		if (srst) begin
			done <= 1'b0;
			illegal <= 1'b0;
			lastStates <= 5'd0;
			lastCycles <= 3'd0;
		end else if (ce) begin
			if (lastState) begin
				done <= 1'b1;
				lastStates <= timeHold.total; // RQ9 RQ14
				lastCycles <= timeHold.mCycles;
			end else if (clearReq) begin
				done <= 1'b0;
			end
			if (startReq && dOp == ALU_NONE)
				illegal <= 1'b1;
			else if (clearReq)
				illegal <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read data, registered in the setup phase
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			prdata <= 32'h0000_0000;
		end else if (apbSetup) begin
			unique case (paddr)
				ADDR_INSTR: prdata <= instr;
				ADDR_STATUS: prdata <= {29'h0000_0000, illegal, done, busy};
				ADDR_ACCF: prdata <= {16'h0000, flags, acc};
				ADDR_BCDE: prdata <= {regB, regC, regD, regE};
				ADDR_PTR: prdata <= {16'h0000, regH, regL};
				ADDR_INDEX: prdata <= {idxSecond, idxFirst};
				ADDR_TIMING: prdata <= {21'h00_0000, lastCycles, 3'h0, lastStates};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule : shift_digit_rotate_unit

/* File: sim/mem_model.sv */
// Purpose: Byte memory that answers the unit's read and write-back requests.
// Assumes: Requests hold until memReady; waitCycles sets the stall length.
// Notes: Outside an accepted read the data bus shows the inverse of the last read.
`timescale 1ns/1ps
module mem_model (
	input wire logic clk,
	input wire logic [15:0] memAddr,
	input wire logic memRead,
	input wire logic memWrite,
	input wire logic [7:0] memWdata,
	input wire logic [3:0] waitCycles,
	output logic [7:0] memRdata,
	output logic memReady
);
	logic [7:0] store [0:65535];
	logic [3:0] waited = 4'h0;
	logic [7:0] lastData = 8'h00;
	// Stale data is inverted so a late sample never looks right by chance
	assign memReady = (memRead || memWrite) && waited >= waitCycles;
	assign memRdata = (memRead && memReady) ? store[memAddr] : ~lastData;
	// Count stall states, then accept the access
	always @(posedge clk) begin
		if ((memRead || memWrite) && !memReady) begin
			waited <= waited + 4'h1;
		end else begin
			waited <= 4'h0;
		end
		if (memRead && memReady) begin
			lastData <= store[memAddr];
		end
		if (memWrite && memReady) begin
			store[memAddr] <= memWdata;
		end
	end
endmodule : mem_model

/* File: sim/shift_digit_properties.sv */
// Purpose: Port checks for the shift and digit-rotate unit.
// Assumes: ce stays high while an instruction runs.
// Notes: Tracks INSTR writes and the read byte to predict write-back data.
`timescale 1ns/1ps
module shift_digit_properties import shift_digit_pkg::*; (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [15:0] memAddr,
	input wire logic memRead,
	input wire logic memWrite,
	input wire logic [7:0] memWdata,
	input wire logic [7:0] memRdata,
	input wire logic memReady
);
	logic [31:0] instr;
	logic [7:0] rdByte;
	logic [15:0] rdAddr;
	logic rdSeen;
	logic [7:0] opByte;
	logic [7:0] expW;
	logic mapped;
	logic isDigit;
	// Remember the instruction and the byte read, for write-back prediction
	always_ff @(posedge clk) begin
		if (psel && penable && pwrite && ce && paddr == ADDR_INSTR) begin
			instr <= pwdata;
		end
		if (memRead && memReady && ce) begin
			rdByte <= memRdata;
			rdAddr <= memAddr;
		end
	end
	// A write-back is only legal after a read of the same instruction
	always_ff @(posedge clk) begin
		if (srst) begin
			rdSeen <= 1'b0;
		end else if (memRead && memReady && ce) begin
			rdSeen <= 1'b1;
		end else if (memWrite && memReady && ce) begin
			rdSeen <= 1'b0;
		end
	end
	assign isDigit = instr[7:0] == OP_PREFIX_EXT;
	assign opByte = (instr[7:0] == OP_PREFIX_SHIFT) ? instr[15:8] : instr[31:24];
	assign expW = {(opByte == 8'h2e) & rdByte[7], rdByte[7:1]};
	assign mapped = paddr <= ADDR_TIMING && paddr[1:0] == 2'h0;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	a_ready_no_wait: assert property (psel && penable |-> pready == ce)
		else $error("pready differs from ce in access phase");
	a_unmapped_error: assert property (psel && penable && !mapped |-> pslverr)
		else $error("unmapped access without error");
	a_mapped_clean: assert property (psel && penable && mapped |-> !pslverr)
		else $error("mapped access flagged as error");
	a_one_access: assert property (!(memRead && memWrite))
		else $error("read and write at once");
	a_read_held: assert property (memRead && !memReady && ce |=> memRead && $stable(memAddr))
		else $error("read dropped before acknowledge");
	a_write_back_addr: assert property (memWrite |-> rdSeen && memAddr == rdAddr)
		else $error("write-back not to the address read");
	a_shift_result: assert property (memWrite && !isDigit |-> memWdata == expW)
		else $error("shift write data wrong");
	a_shift_gap: assert property (memRead && memReady && ce && !isDigit |-> ##4 memWrite)
		else $error("shift write-back not four states after read");
	a_digit_gap: assert property (memRead && memReady && ce && isDigit |-> ##7 memWrite)
		else $error("digit write-back not seven states after read");
	a_reset_quiet: assert property (disable iff (1'b0) srst |=> !memRead && !memWrite
		&& memAddr == 16'h0000)
		else $error("memory port active after reset");
	c_ptr_write: cover property (memWrite && memReady && instr[7:0] == OP_PREFIX_SHIFT);
	c_idx_write: cover property (memWrite && memReady && instr[7:0] == OP_PREFIX_SECOND);
	c_digit_write: cover property (memWrite && memReady && isDigit);
	c_read_wait: cover property (memRead && !memReady);
endmodule : shift_digit_properties

bind shift_digit_rotate_unit shift_digit_properties chk (.clk(clk), .srst(srst), .ce(ce),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr), .memAddr(memAddr), .memRead(memRead),
	.memWrite(memWrite), .memWdata(memWdata), .memRdata(memRdata), .memReady(memReady));

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench for the shift and digit-rotate unit.
// Assumes: ce held high; registers reached over APB only.
// Notes: Expected shifts and flags come from the bench's own functions; digit rotate results are given as literals.
`timescale 1ns/1ps
module tb_top;
	import shift_digit_pkg::*;
	logic clk, srst, ce, psel, penable, pwrite, pready, pslverr, memRead, memWrite, memReady;
	logic [7:0] paddr, memWdata, memRdata;
	logic [31:0] pwdata, prdata, rdata;
	logic [15:0] memAddr;
	logic [3:0] waitCycles;
	logic err;
	int n_fail = 0;
	int compares = 0;
	shift_digit_rotate_unit dut (.clk(clk), .srst(srst), .ce(ce), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .memAddr(memAddr), .memRead(memRead), .memWrite(memWrite),
		.memWdata(memWdata), .memRdata(memRdata), .memReady(memReady));
	mem_model u_mem (.clk(clk), .memAddr(memAddr), .memRead(memRead), .memWrite(memWrite),
		.memWdata(memWdata), .waitCycles(waitCycles), .memRdata(memRdata), .memReady(memReady));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// One APB transfer; only the watchdog ends a wait on pready
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		apb(a, 1'b0, 32'h0);
	endtask : rd
	function automatic logic [7:0] fl(input logic [7:0] r, input logic c);
		return {r[7], r == 8'h00, 3'h0, ~^r, 1'b0, c};
	endfunction : fl
	function automatic logic [15:0] shr(input logic ar, input logic [7:0] v);
		logic [7:0] r;
		r = {ar & v[7], v[7:1]};
		return {fl(r, v[0]), r};
	endfunction : shr
	task automatic load(input logic [31:0] bcde, input logic [15:0] ptr, input logic [15:0] af);
		wr(ADDR_BCDE, bcde);
		wr(ADDR_PTR, {16'h0, ptr});
		wr(ADDR_ACCF, {16'h0, af});
	endtask : load
	// Start, poll for done or illegal, then clear the status
	task automatic run(input logic [31:0] ins, input logic ill);
		int n;
		n = 0;
		wr(ADDR_INSTR, ins);
		wr(ADDR_CTRL, 32'h1);
		do begin
			rd(ADDR_STATUS);
			n++;
		end while (rdata[2:1] === 2'b00 && n < 100);
		check("status", {ill, ~ill, 1'b0}, rdata[2:0]);
		wr(ADDR_CTRL, 32'h2);
		rd(ADDR_STATUS);
		check("status", 32'h0, rdata);
	endtask : run
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rd(ADDR_ACCF);
		check("accf", 32'h0, rdata);
		rd(ADDR_BCDE);
		check("bcde", 32'h0, rdata);
		rd(8'h20);
		check("unmapped", 32'h0, rdata);
		check("slverr", 32'h1, {31'h0, err});
		$display("reset test done");
	endtask : t_reset
	// Every register code with both shifts; the others must stay put
	task automatic t_regs();
		logic [7:0] v [8];
		logic [7:0] got [8];
		logic [31:0] bc, pp;
		logic [15:0] e;
		v = '{8'h81, 8'h02, 8'h8f, 8'h00, 8'h41, 8'h03, 8'h00, 8'hc5};
		for (int op = 0; op < 2; op++) begin
			for (int r = 0; r < 8; r++) begin
				if (r == 6) continue;
				load({v[0], v[1], v[2], v[3]}, {v[4], v[5]}, {8'hff, v[7]});
				run({16'h0, (op == 1) ? 5'h07 : 5'h05, 3'(r), OP_PREFIX_SHIFT}, 1'b0);
				rd(ADDR_BCDE);
				bc = rdata;
				rd(ADDR_PTR);
				pp = rdata;
				rd(ADDR_ACCF);
				got = '{bc[31:24], bc[23:16], bc[15:8], bc[7:0], pp[15:8], pp[7:0], 8'h0, rdata[7:0]};
				e = shr(op == 0, v[r]);
				for (int k = 0; k < 8; k++) begin
					check("reg", (k == r) ? e[7:0] : v[k], got[k]);
				end
				check("flags", e[15:8], rdata[15:8]);
				rd(ADDR_TIMING);
				check("timing", {3'd2, 3'h0, 5'd8}, rdata[10:0]);
			end
		end
		$display("register shift test done");
	endtask : t_regs
	task automatic memcase(input logic [31:0] ins, input logic [15:0] ptr, input logic [31:0] idx,
		input logic [15:0] a, input logic [7:0] val, input logic ar, input logic [3:0] w,
		input logic [4:0] st);
		logic [15:0] e;
		e = shr(ar, val);
		waitCycles <= w;
		u_mem.store[a] = val;
		load(32'h0, ptr, 16'hffff);
		wr(ADDR_INDEX, idx);
		run(ins, 1'b0);
		check("mem", e[7:0], u_mem.store[a]);
		rd(ADDR_ACCF);
		check("flags", e[15:8], rdata[15:8]);
		rd(ADDR_TIMING);
		check("states", st, rdata[4:0]);
		waitCycles <= 4'h0;
	endtask : memcase
	task automatic t_mem();
		memcase({16'h0, 8'h2e, OP_PREFIX_SHIFT}, 16'h4343, 32'h0, 16'h4343, 8'hb9, 1, 0, 15);
		memcase({16'h0, 8'h3e, OP_PREFIX_SHIFT}, 16'h8000, 32'h0, 16'h8000, 8'h01, 0, 3, 15);
		memcase({8'h2e, 8'h03, OP_PREFIX_SHIFT, OP_PREFIX_FIRST}, 0, 32'h1000, 16'h1003,
			8'hb8, 1, 0, 23);
		memcase({8'h3e, 8'hfe, OP_PREFIX_SHIFT, OP_PREFIX_SECOND}, 0, 32'h2001_0000, 16'h1fff,
			8'h8f, 0, 2, 23);
		$display("memory shift test done");
	endtask : t_mem
	task automatic digcase(input logic [7:0] op, input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] ea, input logic [7:0] em);
		u_mem.store[16'h5000] = m;
		load(32'h0, 16'h5000, {8'hff, a});
		run({16'h0, op, OP_PREFIX_EXT}, 1'b0);
		check("mem", em, u_mem.store[16'h5000]);
		rd(ADDR_ACCF);
		check("acc", {fl(ea, 1'b1), ea}, rdata[15:0]);
		rd(ADDR_TIMING);
		check("timing", {3'd5, 3'h0, 5'd18}, rdata[10:0]);
	endtask : digcase
	task automatic t_digit();
		digcase(OP_DIGIT_LEFT, 8'h7a, 8'h31, 8'h73, 8'h1a);
		digcase(OP_DIGIT_RIGHT, 8'h84, 8'h20, 8'h80, 8'h42);
		digcase(OP_DIGIT_RIGHT, 8'h05, 8'h30, 8'h00, 8'h53);
		$display("digit rotate test done");
	endtask : t_digit
	// Codes outside the group must not touch memory
	task automatic t_illegal();
		u_mem.store[16'h6000] = 8'h55;
		load(32'h0, 16'h6000, 16'h0);
		run({16'h0, 8'h06, OP_PREFIX_SHIFT}, 1'b1);
		run({8'h2f, 8'h00, OP_PREFIX_SHIFT, OP_PREFIX_FIRST}, 1'b1);
		check("untouched", 8'h55, u_mem.store[16'h6000]);
		$display("illegal code test done");
	endtask : t_illegal
	initial begin
		srst = 1'b1;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		waitCycles = 4'h0;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_regs();
		t_mem();
		t_digit();
		t_illegal();
		stop_test();
	end
	// Whole run needs about a thousand cycles; this cuts a hang short
	initial begin
		repeat (40000) @(posedge clk);
		n_fail++;
		stop_test();
	end
endmodule : tb_top
